// >>> hw/plt_tester.sv
// loopback pattern tester: generators, checkers, counters and run control
// assumes host strobes come from this clock; lock inputs are asynchronous
//
// Summary of operation
// - prbs orders 7, 15, 23, 31, checker follows
// - four-level build adds orders 9 and 11
// - fast selection emits alternating one-zero bits
// - slow selection emits square wave, period 33
// - each insert request corrupts one word on every channel of the selected group
// - insert requests ignored unless test running
// - inserted counter counts every injected word error
// - detected counter counts received bit errors only while the channel is synced
// - clear zeroes detected and inserted counters together
// - synced status set after four matching words in a row
// - per-channel clock generator lock is reported
// - lock, sync and errors readable per channel
// - start strobe toggles between idle and running
// - serial loopback feeds transmit words to checker
// - transmit and receive bytes per second measured
// - checked bit count given for error rate
// - port selector picks the controlled channel group

module plt_tester
  import plt_pkg::*;
#(
  parameter int NUM_GRP = 2,
  parameter int GRP_CH = 4,
  parameter bit FOUR_LEVEL = 1'b1,
  parameter int WINDOW_LEN = plt_pkg::WINDOW_CYCLES,
  parameter int GRP_W = (NUM_GRP > 1) ? $clog2(NUM_GRP) : 1,
  parameter int NUM_CH = NUM_GRP * GRP_CH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host control
  input wire logic [GRP_W-1:0] port_sel,
  input wire plt_pkg::plt_mode_t mode_sel,
  input wire logic loopback_sel,
  input wire logic start_toggle,
  input wire logic insert_error,
  input wire logic clear_counts,
  // status
  output logic [NUM_GRP-1:0] group_running,
  output logic [NUM_CH-1:0] pll_locked,
  output logic [NUM_CH-1:0] pattern_synced,
  output logic [NUM_CH*plt_pkg::CNT_W-1:0] detected_errors,
  output logic [NUM_CH*plt_pkg::CNT_W-1:0] inserted_errors,
  output logic [NUM_CH*plt_pkg::CHK_W-1:0] checked_bits,
  output logic [NUM_CH*plt_pkg::CNT_W-1:0] tx_bytes_per_s,
  output logic [NUM_CH*plt_pkg::CNT_W-1:0] rx_bytes_per_s,
  // serial lane units
  input wire logic [NUM_CH-1:0] pll_lock_raw,
  output logic [NUM_CH*plt_pkg::DATA_W-1:0] tx_data,
  output logic [NUM_CH-1:0] tx_valid,
  input wire logic [NUM_CH-1:0] tx_ready,
  input wire logic [NUM_CH*plt_pkg::DATA_W-1:0] rx_data,
  input wire logic [NUM_CH-1:0] rx_valid,
  output logic [NUM_CH-1:0] serial_loopback
);
  localparam int SEC_W = $clog2(WINDOW_LEN + 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(WINDOW_LEN - 1);
  localparam logic [2:0] GOOD_LAST = 3'(SYNC_GOOD - 1);
  localparam logic [2:0] BAD_LAST = 3'(SYNC_BAD - 1);
  localparam logic [CNT_W-1:0] WORD_BYTES = CNT_W'(BYTES_PER_WORD);
  localparam logic [CHK_W-1:0] WORD_BITS = CHK_W'(DATA_W);

  typedef struct packed {
    plt_run_t [NUM_GRP-1:0] run;
    plt_mode_t [NUM_GRP-1:0] mode;
    logic [NUM_GRP-1:0] loop;
    logic [NUM_CH-1:0] lock_meta;
    logic [NUM_CH-1:0] lock_sync;
    logic [NUM_CH-1:0][HIST_W-1:0] rx_hist;
    logic [NUM_CH-1:0][1:0] prime;
    logic [NUM_CH-1:0][2:0] good;
    logic [NUM_CH-1:0][2:0] bad;
    logic [NUM_CH-1:0] synced;
    logic [NUM_CH-1:0][CNT_W-1:0] det;
    logic [NUM_CH-1:0][CNT_W-1:0] ins;
    logic [NUM_CH-1:0][CHK_W-1:0] chk;
    logic [NUM_CH-1:0][CNT_W-1:0] tx_acc;
    logic [NUM_CH-1:0][CNT_W-1:0] rx_acc;
    logic [NUM_CH-1:0][CNT_W-1:0] tx_rate;
    logic [NUM_CH-1:0][CNT_W-1:0] rx_rate;
    logic [SEC_W-1:0] sec;
  } plt_state_t;

  plt_state_t s_q;
  plt_state_t s_d;

  logic [NUM_GRP-1:0] grp_sel;
  logic [NUM_GRP-1:0] grp_run;
  logic [NUM_GRP-1:0] restart;
  logic [NUM_CH-1:0] ins_req;
  logic [NUM_CH-1:0] gen_valid;
  logic [NUM_CH-1:0] gen_ready;
  logic [NUM_CH-1:0][DATA_W-1:0] gen_data;
  logic [NUM_CH-1:0] gen_ins;
  logic [NUM_CH-1:0] tx_fire;
  logic [NUM_CH-1:0] chk_valid;
  logic [NUM_CH-1:0][DATA_W-1:0] chk_word;
  logic win_end;

  // orders 9 and 11 exist only in the four-level build
  function automatic plt_mode_t eff_mode(plt_mode_t m);
    if (!FOUR_LEVEL && (m == PLT_PRBS9 || m == PLT_PRBS11)) begin
      return PLT_PRBS7;
    end
    return m;
  endfunction

  // ****************************************
  // group control
  // ****************************************
  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    assign grp_sel[g] = port_sel == GRP_W'(g);
    assign grp_run[g] = s_q.run[g] == PLT_RUN;
    assign restart[g] = start_toggle & grp_sel[g] & ~grp_run[g];
    assign group_running[g] = grp_run[g];
  end

  // ****************************************
  // channel datapath
  // ****************************************
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int G = c / GRP_CH;
    assign ins_req[c] = insert_error & grp_sel[G] & grp_run[G];
    plt_gen u_gen (
      .clk(clk),
      .reset(reset),
      .restart(restart[G]),
      .run(grp_run[G]),
      // a restarting generator must seed with the mode being latched, not the old one
      .mode(restart[G] ? eff_mode(mode_sel) : s_q.mode[G]),
      .insert_req(ins_req[c]),
      .out_valid(gen_valid[c]),
      .out_ready(gen_ready[c]),
      .out_data(gen_data[c]),
      .inserted(gen_ins[c])
    );
    // a stalled lane fills the buffer and then holds the generator
    plt_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(gen_valid[c]),
      .in_ready(gen_ready[c]),
      .in_data(gen_data[c]),
      .out_valid(tx_valid[c]),
      .out_ready(tx_ready[c]),
      .out_data(tx_data[c*DATA_W+:DATA_W])
    );
    assign tx_fire[c] = tx_valid[c] & tx_ready[c];
    assign chk_valid[c] = s_q.loop[G] ? tx_fire[c] : rx_valid[c];
    assign chk_word[c] = s_q.loop[G] ? tx_data[c*DATA_W+:DATA_W] : rx_data[c*DATA_W+:DATA_W];
    assign serial_loopback[c] = s_q.loop[G];
  end

  assign win_end = s_q.sec == SEC_LAST;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    int g;
    logic [DATA_W-1:0] expect_w;
    logic [POP_W-1:0] nbad;
    logic [CNT_W-1:0] det_inc;
    logic [CNT_W-1:0] tx_inc;
    logic [CNT_W-1:0] rx_inc;
    logic [CHK_W-1:0] chk_inc;
    logic clr;
    g = 0;
    expect_w = '0;
    nbad = '0;
    det_inc = '0;
    tx_inc = '0;
    rx_inc = '0;
    chk_inc = '0;
    clr = 1'b0;
    s_d = s_q;
    s_d.sec = win_end ? '0 : s_q.sec + 1'b1;
    s_d.lock_meta = pll_lock_raw;
    s_d.lock_sync = s_q.lock_meta;
    for (int k = 0; k < NUM_GRP; k++) begin
      if (start_toggle && grp_sel[k]) begin
        if (s_q.run[k] == PLT_IDLE) begin
          s_d.run[k] = PLT_RUN;
          s_d.mode[k] = eff_mode(mode_sel);
          s_d.loop[k] = loopback_sel;
        end else begin
          s_d.run[k] = PLT_IDLE;
        end
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      g = c / GRP_CH;
      clr = clear_counts & grp_sel[g];
      det_inc = '0;
      chk_inc = '0;
      rx_inc = '0;
      tx_inc = tx_fire[c] ? WORD_BYTES : '0;
      if (restart[g] || !grp_run[g]) begin
        s_d.prime[c] = '0;
        s_d.good[c] = '0;
        s_d.bad[c] = '0;
        s_d.synced[c] = 1'b0;
      end else if (chk_valid[c]) begin
        rx_inc = WORD_BYTES;
        s_d.rx_hist[c] = {chk_word[c], s_q.rx_hist[c][HIST_W-1:DATA_W]};
        if (s_q.prime[c] != 2'h2) begin
          s_d.prime[c] = s_q.prime[c] + 1'b1;
        end else begin
          // self-aligning: expected word comes from the received history
          expect_w = next_word(s_q.mode[g], s_q.rx_hist[c]);
          nbad = count_ones(expect_w ^ chk_word[c]);
          if (s_q.synced[c]) begin
            det_inc = CNT_W'(nbad);
            chk_inc = WORD_BITS;
          end
          if (nbad == '0) begin
            s_d.bad[c] = '0;
            if (s_q.good[c] == GOOD_LAST) begin
              s_d.synced[c] = 1'b1;
            end else begin
              s_d.good[c] = s_q.good[c] + 1'b1;
            end
          end else begin
            s_d.good[c] = '0;
            s_d.bad[c] = s_q.bad[c] + 1'b1;
            if (s_q.bad[c] == BAD_LAST) begin
              s_d.synced[c] = 1'b0;
              s_d.bad[c] = '0;
            end
          end
        end
      end
      // an event in the clearing cycle still counts
      s_d.det[c] = (clr ? '0 : s_q.det[c]) + det_inc;
      s_d.ins[c] = (clr ? '0 : s_q.ins[c]) + CNT_W'(gen_ins[c]);
      s_d.chk[c] = (clr ? '0 : s_q.chk[c]) + chk_inc;
      // the window-end cycle belongs to the closing window only
      s_d.tx_acc[c] = win_end ? '0 : s_q.tx_acc[c] + tx_inc;
      s_d.rx_acc[c] = win_end ? '0 : s_q.rx_acc[c] + rx_inc;
      if (win_end) begin
        s_d.tx_rate[c] = s_q.tx_acc[c] + tx_inc;
        s_d.rx_rate[c] = s_q.rx_acc[c] + rx_inc;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  assign pll_locked = s_q.lock_sync;
  assign pattern_synced = s_q.synced;
  assign detected_errors = s_q.det;
  assign inserted_errors = s_q.ins;
  assign checked_bits = s_q.chk;
  assign tx_bytes_per_s = s_q.tx_rate;
  assign rx_bytes_per_s = s_q.rx_rate;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  start_run_a: assert property (
    start_toggle && grp_sel[0] && !grp_run[0] |=> grp_run[0] && s_q.mode[0] == eff_mode($past(mode_sel)))
    else $error("start while idle did not begin the test");
  stop_run_a: assert property (
    start_toggle && grp_sel[0] && grp_run[0] |=> !grp_run[0])
    else $error("start while running did not stop the test");
  insert_idle_a: assert property (!grp_run[0] |-> !ins_req[0])
    else $error("insert request passed while idle");
  ins_count_a: assert property (
    gen_ins[0] && !(clear_counts && grp_sel[0]) |=> s_q.ins[0] == $past(s_q.ins[0]) + 1)
    else $error("inserted counter missed an injection");
  clear_both_a: assert property (
    clear_counts && grp_sel[0] |=> s_q.det[0] <= DATA_W && s_q.ins[0] <= 1)
    else $error("clear left a counter standing");
  sync_idle_a: assert property (!grp_run[0] |=> !s_q.synced[0])
    else $error("synced shown while idle");
  lock_pass_a: assert property (pll_lock_raw[0] [*4] |-> pll_locked[0])
    else $error("lock not reported after two stages");
  det_unsync_a: assert property (
    !s_q.synced[0] |=> s_q.det[0] == $past(s_q.det[0]) || s_q.det[0] == 0)
    else $error("errors counted while not synced");
  loop_route_a: assert property (s_q.loop[0] |-> chk_valid[0] == tx_fire[0])
    else $error("loopback did not feed the checker");
  rate_take_a: assert property (
    win_end |=> s_q.tx_rate[0] == $past(s_q.tx_acc[0]) + ($past(tx_fire[0]) ? WORD_BYTES : 0))
    else $error("transmit rate not taken at window end");
  clean_sync_a: assert property (
    s_q.synced[0] && grp_run[0] && chk_valid[0] && s_q.prime[0] == 2'h2 &&
    chk_word[0] != next_word(s_q.mode[0], s_q.rx_hist[0]) |=> s_q.det[0] != $past(s_q.det[0]))
    else $error("mismatch not counted");

  sync_seen_c: cover property (grp_run[0] ##1 $rose(s_q.synced[0]));
  insert_seen_c: cover property (gen_ins[0] ##[1:40] s_q.det[0] != 0);
  rate_seen_c: cover property (win_end ##1 s_q.rx_rate[0] != 0);

endmodule

// >>> hw/plt_pkg.sv
// shared constants, types and pattern functions of the loopback tester
// assumes a word-parallel lane interface, bit 0 of a word is first in time

package plt_pkg;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int DATA_W = 32;
  localparam int HIST_W = 2 * DATA_W;
  localparam int POP_W = $clog2(DATA_W + 1);
  localparam int CNT_W = 32;
  localparam int CHK_W = 48;
  localparam int BYTES_PER_WORD = DATA_W / 8;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int WINDOW_S = 1;
  localparam int WINDOW_CYCLES = WINDOW_S * CLK_HZ;
  localparam int SYNC_GOOD = 4;
  localparam int SYNC_BAD = 4;

  // ****************************************
  // pattern recurrences: b[t] = b[t-long] ^ b[t-short]
  // ****************************************
  localparam int PRBS7_LONG = 7;
  localparam int PRBS7_SHORT = 6;
  localparam int PRBS9_LONG = 9;
  localparam int PRBS9_SHORT = 5;
  localparam int PRBS11_LONG = 11;
  localparam int PRBS11_SHORT = 9;
  localparam int PRBS15_LONG = 15;
  localparam int PRBS15_SHORT = 14;
  localparam int PRBS23_LONG = 23;
  localparam int PRBS23_SHORT = 18;
  localparam int PRBS31_LONG = 31;
  localparam int PRBS31_SHORT = 28;
  localparam int FAST_PERIOD = 2;
  localparam int SLOW_PERIOD = 33;
  localparam logic [HIST_W-1:0] SEED_PRBS = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [HIST_W-1:0] SEED_FAST = 64'h5555_5555_5555_5555;
  // 17 ones then 16 zeros, repeated
  localparam logic [HIST_W-1:0] SEED_SLOW = 64'h0003_FFFE_0001_FFFF;
  localparam logic [DATA_W-1:0] FAST_WORD = 32'h5555_5555;
  localparam logic [DATA_W-1:0] ERR_MASK = 32'h0000_0001;

  typedef enum logic [2:0] {
    PLT_PRBS7 = 3'h0,
    PLT_PRBS15 = 3'h1,
    PLT_PRBS23 = 3'h2,
    PLT_PRBS31 = 3'h3,
    PLT_PRBS9 = 3'h4,
    PLT_PRBS11 = 3'h5,
    PLT_FAST_TOGGLE = 3'h6,
    PLT_SLOW_SQUARE = 3'h7
  } plt_mode_t;

  typedef enum logic {
    PLT_IDLE = 1'b0,
    PLT_RUN = 1'b1
  } plt_run_t;

  function automatic int tap_long(plt_mode_t m);
    case (m)
      PLT_PRBS7: return PRBS7_LONG;
      PLT_PRBS9: return PRBS9_LONG;
      PLT_PRBS11: return PRBS11_LONG;
      PLT_PRBS15: return PRBS15_LONG;
      PLT_PRBS23: return PRBS23_LONG;
      PLT_PRBS31: return PRBS31_LONG;
      PLT_FAST_TOGGLE: return FAST_PERIOD;
      default: return SLOW_PERIOD;
    endcase
  endfunction

  // zero means the recurrence is a plain repeat
  function automatic int tap_short(plt_mode_t m);
    case (m)
      PLT_PRBS7: return PRBS7_SHORT;
      PLT_PRBS9: return PRBS9_SHORT;
      PLT_PRBS11: return PRBS11_SHORT;
      PLT_PRBS15: return PRBS15_SHORT;
      PLT_PRBS23: return PRBS23_SHORT;
      PLT_PRBS31: return PRBS31_SHORT;
      default: return 0;
    endcase
  endfunction

  function automatic logic [HIST_W-1:0] seed_hist(plt_mode_t m);
    case (m)
      PLT_FAST_TOGGLE: return SEED_FAST;
      PLT_SLOW_SQUARE: return SEED_SLOW;
      default: return SEED_PRBS;
    endcase
  endfunction

  // next word predicted from the two previous words (oldest bit at 0)
  function automatic logic [DATA_W-1:0] next_word(plt_mode_t m, logic [HIST_W-1:0] h);
    logic [HIST_W+DATA_W-1:0] s;
    int n;
    int k;
    s = {{DATA_W{1'b0}}, h};
    n = tap_long(m);
    k = tap_short(m);
    for (int i = HIST_W; i < HIST_W + DATA_W; i++) begin
      s[i] = s[i-n] ^ ((k != 0) ? s[i-k] : 1'b0);
    end
    return s[HIST_W+:DATA_W];
  endfunction

  function automatic logic [POP_W-1:0] count_ones(logic [DATA_W-1:0] v);
    logic [POP_W-1:0] n;
    n = '0;
    for (int i = 0; i < DATA_W; i++) begin
      n = n + POP_W'(v[i]);
    end
    return n;
  endfunction

endpackage

// >>> hw/plt_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes DEPTH is at least 2; storage is flip-flops, data leave from them

module plt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } plt_fifo_t;

  plt_fifo_t s_q;
  plt_fifo_t s_d;
  logic push;
  logic pop;

  assign in_ready = s_q.cnt != FULL_CNT;
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == LAST_IDX) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == LAST_IDX) ? '0 : s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// >>> hw/plt_gen.sv
// pattern generator of one channel, with one-word error insertion
// assumes restart is a one-cycle pulse and the drain side may stall it

module plt_gen
  import plt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic restart,
  input wire logic run,
  input wire plt_pkg::plt_mode_t mode,
  input wire logic insert_req,
  // word stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [plt_pkg::DATA_W-1:0] out_data,
  output logic inserted
);
  typedef struct packed {
    logic [HIST_W-1:0] hist;
    logic [DATA_W-1:0] word;
    logic pending;
  } plt_gen_t;

  plt_gen_t s_q;
  plt_gen_t s_d;
  logic fire;

  assign out_valid = run & ~restart;
  assign fire = out_valid & out_ready;
  assign out_data = s_q.pending ? (s_q.word ^ ERR_MASK) : s_q.word;
  assign inserted = fire & s_q.pending;

  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d.hist = seed_hist(mode);
      s_d.word = next_word(mode, seed_hist(mode));
    end else if (fire) begin
      // history keeps the clean word so the stream stays on its sequence
      s_d.hist = {s_q.word, s_q.hist[HIST_W-1:DATA_W]};
      s_d.word = next_word(mode, {s_q.word, s_q.hist[HIST_W-1:DATA_W]});
    end
    // a new request wins over the clear of a word just sent
    s_d.pending = (s_q.pending & ~fire) | insert_req;
    if (restart) begin
      s_d.pending = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  ins_one_word_a: assert property (@(posedge clk) disable iff (reset)
    fire && s_q.pending |=> !s_q.pending || $past(insert_req))
    else $error("insertion corrupted more than one word");
  fast_toggle_a: assert property (@(posedge clk) disable iff (reset)
    mode == PLT_FAST_TOGGLE && fire && !s_q.pending |-> out_data == FAST_WORD)
    else $error("fast toggle word is not alternating");

endmodule

// >>> bench/plt_loop_model.sv
// loopback cable model: hands every taken transmit word back one cycle later, except on a cut channel
// assumes the tester's clock; stall and cut are set by the bench
module plt_loop_model #(
  parameter int NUM_CH = 8,
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bench control
  input wire logic [NUM_CH-1:0] stall,
  input wire logic [NUM_CH-1:0] cut,
  // tester side
  input wire logic [NUM_CH*W-1:0] tx_data,
  input wire logic [NUM_CH-1:0] tx_valid,
  output logic [NUM_CH-1:0] tx_ready,
  output logic [NUM_CH*W-1:0] rx_data,
  output logic [NUM_CH-1:0] rx_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  assign tx_ready = ~stall;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_valid <= '0;
      rx_data <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        rx_valid[c] <= tx_valid[c] & tx_ready[c] & ~cut[c];
        // an idle line inverts its data every cycle, alternating between its last word and that word's inverse
        rx_data[c*W+:W] <= (tx_valid[c] & tx_ready[c]) ? tx_data[c*W+:W] : ~rx_data[c*W+:W];
      end
    end
  end
endmodule

// >>> bench/plt_tester_tb.sv
// self-checking bench of the loopback tester with a cable model on the lanes
// assumes the tester's default of two groups of four channels
module plt_tester_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import plt_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  // short window keeps the rate check inside a few hundred cycles
  localparam int WIN = 50;
  localparam int NCH = 8;
  logic clk;
  logic reset;
  logic port_sel;
  plt_mode_t mode_sel;
  logic loopback_sel, start_toggle, insert_error, clear_counts;
  logic [1:0] group_running;
  logic [NCH-1:0] pll_locked, pattern_synced, pll_lock_raw, tx_valid, tx_ready;
  logic [NCH-1:0] rx_valid, serial_loopback, stall, cut;
  logic [NCH*CNT_W-1:0] detected_errors, inserted_errors, tx_bytes_per_s, rx_bytes_per_s;
  logic [NCH*CHK_W-1:0] checked_bits;
  logic [NCH*DATA_W-1:0] tx_data, rx_data;
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] held;
  int error_cnt = 0;
  int total_checks = 0;
  int n_tab [8] = '{7, 15, 23, 31, 9, 11, 2, 33};
  int m_tab [8] = '{6, 14, 18, 28, 5, 9, 0, 0};

  plt_tester #(.WINDOW_LEN(WIN)) u_plt_tester (
    .clk(clk), .reset(reset), .port_sel(port_sel), .mode_sel(mode_sel),
    .loopback_sel(loopback_sel), .start_toggle(start_toggle),
    .insert_error(insert_error), .clear_counts(clear_counts),
    .group_running(group_running), .pll_locked(pll_locked),
    .pattern_synced(pattern_synced), .detected_errors(detected_errors),
    .inserted_errors(inserted_errors), .checked_bits(checked_bits),
    .tx_bytes_per_s(tx_bytes_per_s), .rx_bytes_per_s(rx_bytes_per_s),
    .pll_lock_raw(pll_lock_raw), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .serial_loopback(serial_loopback)
  );

  plt_loop_model #(.NUM_CH(NCH), .W(DATA_W)) u_plt_loop_model (
    .clk(clk), .reset(reset), .stall(stall), .cut(cut), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // words taken on channel 0, bit 0 first in time
  always @(posedge clk) begin
    if (!reset && tx_valid[0] && tx_ready[0]) q.push_back(tx_data[DATA_W-1:0]);
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // kind 0 start, 1 insert, 2 clear; one-cycle pulse for group g
  task automatic strobe(input int kind, input logic g);
    @(posedge clk);
    port_sel <= g;
    start_toggle <= (kind == 0);
    insert_error <= (kind == 1);
    clear_counts <= (kind == 2);
    @(posedge clk);
    start_toggle <= 1'b0;
    insert_error <= 1'b0;
    clear_counts <= 1'b0;
    #1;
  endtask

  task automatic wait_sync(input int ch);
    int i;
    for (i = 0; i < 200 && pattern_synced[ch] !== 1'b1; i++) tick(1);
    if (i == 200) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // of six taken words, the last four must obey the mode's recurrence across their word seams
  task automatic check_stream(input int m);
    logic [191:0] b;
    logic [8:0] err;
    logic [8:0] ones;
    int i;
    for (i = 0; i < 200 && q.size() < 6; i++) tick(1);
    if (q.size() < 6) begin
      error_cnt++;
      tally_and_finish();
    end
    b = {q[5], q[4], q[3], q[2], q[1], q[0]};
    err = '0;
    ones = '0;
    for (int t = 64; t < 192; t++) begin
      err = err + 9'(b[t] ^ b[t-n_tab[m]] ^ (m_tab[m] != 0 && b[t-m_tab[m]]));
    end
    for (int t = 64; t < 97; t++) ones = ones + 9'(b[t]);
    chk(err, 9'h000);
    if (m == 7) chk(ones, 9'h011);
    if (m == 6) chk(q[0], FAST_WORD);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    port_sel = 1'b0;
    mode_sel = PLT_PRBS7;
    loopback_sel = 1'b0;
    start_toggle = 1'b0;
    insert_error = 1'b0;
    clear_counts = 1'b0;
    pll_lock_raw = 8'hA5;
    stall = '0;
    cut = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    tick(2);
    chk({group_running, tx_valid}, 10'h000);
    chk(detected_errors[CNT_W-1:0], 32'h0);
    chk(pll_locked, 8'hA5);
    pll_lock_raw <= 8'hFF;
    strobe(1, 1'b0);
    tick(4);
    chk(inserted_errors[CNT_W-1:0], 32'h0);
    for (int m = 0; m < 8; m++) begin
      mode_sel <= plt_mode_t'(m);
      strobe(0, 1'b0);
      tick(1);
      chk(group_running, 2'b01);
      wait_sync(0);
      q.delete();
      check_stream(m);
      strobe(0, 1'b0);
      tick(2);
      chk({group_running, pattern_synced[0]}, 3'h0);
    end
    mode_sel <= PLT_PRBS7;
    strobe(0, 1'b0);
    wait_sync(0);
    q.delete();
    stall <= 8'h01;
    tick(2);
    held = tx_data[DATA_W-1:0];
    tick(20);
    chk({tx_valid[0], tx_data[DATA_W-1:0]}, {1'b1, held});
    stall <= 8'h00;
    check_stream(0);
    tick(110);
    chk(tx_bytes_per_s[CNT_W-1:0], 32'hC8);
    chk(rx_bytes_per_s[CNT_W-1:0], 32'hC8);
    chk({checked_bits[CHK_W-1:0] != 0, checked_bits[4:0]}, 6'h20);
    strobe(2, 1'b0);
    tick(2);
    chk(detected_errors[CNT_W-1:0], 32'h0);
    strobe(1, 1'b0);
    tick(40);
    for (int c = 0; c < NCH; c++) begin
      chk({inserted_errors[c*CNT_W+:CNT_W], detected_errors[c*CNT_W+:CNT_W]},
          (c < 4) ? 64'h0000_0001_0000_0001 : 64'h0);
    end
    chk(pattern_synced[3:0], 4'hF);
    strobe(2, 1'b0);
    tick(1);
    chk({inserted_errors[CNT_W-1:0], detected_errors[CNT_W-1:0]}, 64'h0);
    loopback_sel <= 1'b1;
    cut <= 8'hF0;
    mode_sel <= PLT_PRBS31;
    strobe(0, 1'b1);
    tick(2);
    chk(group_running, 2'b11);
    chk(serial_loopback, 8'hF0);
    wait_sync(4);
    strobe(0, 1'b1);
    strobe(0, 1'b0);
    tick(2);
    chk(group_running, 2'b00);
    strobe(1, 1'b0);
    tick(4);
    chk(inserted_errors[CNT_W-1:0], 32'h0);
    chk(pll_locked, 8'hFF);
    tally_and_finish();
  end
endmodule
